// [inc/tmr_pkg.sv]
// Package: register map, field layout, modes and types of the 8-bit timer/counter
package tmr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFFSET    = 8'h14;
  localparam logic [7:0] COMPARE_OFFSET = 8'h18;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] COMPARE_RESET  = 8'hFF;

  // ************************************************************
  // Control field positions
  // ************************************************************
  localparam int RUN_BIT    = 5;
  localparam int SRC_LSB    = 2;
  localparam int MODE_LSB   = 0;
  localparam int DONT_CARE_LSB = 6;

  // ************************************************************
  // Prescaler and source codes
  // ************************************************************
  localparam int          PRESCALE_BITS = 13;
  localparam int          LOW_DIV_LOG2  = 3;
  localparam logic [2:0]  SRC_LOW       = 3'h0;
  localparam logic [2:0]  SRC_EXT       = 3'h7;
  localparam logic [7:0]  COUNT_ZERO    = 8'h00;
  localparam logic [7:0]  COUNT_MAX     = 8'hFF;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_TIMER    = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_DIVIDER  = 2'h2,
    MODE_PWM      = 2'h3
  } mode_type;

  // Control register contents
  typedef struct packed {
    logic       run_enable;
    logic [2:0] source_clock_select;
    mode_type   operating_mode_select;
  } ctrl_type;

  // System-level selects driven by the clock/mode controller
  typedef struct packed {
    logic divider_stage_select;
    logic prescale_halve_select;
    logic low_speed;
    logic stop_entry;
  } sys_type;

  // Board-side outputs
  typedef struct packed {
    logic divider_output_pin;
    logic pwm_output_pin;
    logic match_interrupt;
  } pins_type;

endpackage

// [rtl/tick_select.sv]
// Source tick selector: prescaler taps, low-frequency tap and external count input
`timescale 1ns/1ps
`default_nettype none
module tick_select
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Selection
  input  wire logic [2:0]        src_sel,
  input  wire tmr_pkg::sys_type  sys,
  input  wire logic              run,
  // Sources
  input  wire logic [PRESCALE_BITS-1:0] prescale,
  input  wire logic              low_freq_tick,
  input  wire logic              count_input_pin,
  // Result
  output logic                   count_tick,
  output logic                   fall_tick
);

  logic [PRESCALE_BITS-1:0] prev_reg;
  logic [PRESCALE_BITS-1:0] prev_next;
  logic                     pin_reg;
  logic                     pin_next;
  logic [LOW_DIV_LOG2-1:0]  low_cnt_reg;
  logic [LOW_DIV_LOG2-1:0]  low_cnt_next;

  // Tap of the prescaler that advances for a given source code
  function automatic int tap_of(input logic [2:0] code, input logic halve);
    int t;
    t = 0;
    case (code)
      3'h0:    t = 11;
      3'h1:    t = 7;
      3'h2:    t = 5;
      3'h3:    t = 3;
      3'h4:    t = 2;
      3'h5:    t = 1;
      default: t = 0;
    endcase
    return t + int'(halve);
  endfunction

  // Tick selection, falling tap bit marks a full divided period
  always_comb begin
    int tp;
    tp = tap_of(src_sel, sys.prescale_halve_select);
    prev_next = prescale;
    pin_next = count_input_pin;
    low_cnt_next = low_cnt_reg + {{(LOW_DIV_LOG2-1){1'b0}}, low_freq_tick};
    count_tick = 1'b0;
    fall_tick = 1'b0;
    if (src_sel == SRC_EXT) begin
      count_tick = count_input_pin & ~pin_reg;
      fall_tick = ~count_input_pin & pin_reg;
    end else if ((sys.divider_stage_select && src_sel == SRC_LOW) || sys.low_speed) begin
      // Low-speed states: of codes 000-110 only code 000 has a source
      if (src_sel == SRC_LOW) begin
        count_tick = low_freq_tick && (&low_cnt_reg);
      end
    end else if (tp == 0) begin
      count_tick = 1'b1;
    end else begin
      count_tick = prev_reg[tp-1] & ~prescale[tp-1];
    end
    if (src_sel != SRC_EXT) begin
      fall_tick = count_tick;
    end
    if (!run) begin
      count_tick = 1'b0;
      fall_tick = 1'b0;
    end
  end

  // Edge and divider history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= '0;
      pin_reg <= 1'b0;
      low_cnt_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      pin_reg <= pin_next;
      low_cnt_reg <= low_cnt_next;
    end
  end

endmodule // tick_select
`default_nettype wire

// [rtl/timer_counter.sv]
// Top: 8-bit timer/counter with APB register slave and board-side pins
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Four functions: timer, events, divider, PWM
// - Mode 00 timer, 01 reserved, 10 divider, 11 PWM
// - Run 1 starts; 0 stops, clears count
// - Codes 000-110 pick prescaler taps, halve doubles
// - Code 111 counts external input rising edges
// - Stop-state entry clears run enable
// - Control bits 7:6 read don't care
// - Reset: compare FF, control zero
// - Match raises interrupt, clears counter
// - Divider match toggles pin; high when stopped
// - PWM: match low, overflow high plus interrupt
// - PWM compare buffered until period end/start
module timer_counter
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // System selects
  input  wire tmr_pkg::sys_type  sys,
  input  wire logic              low_freq_tick,
  // Board side
  input  wire logic              count_input_pin,
  output tmr_pkg::pins_type      pins
);

  // ************************************************************
  // State
  // ************************************************************
  ctrl_type                 ctrl_reg;
  ctrl_type                 ctrl_next;
  logic [7:0]               compare_reg;
  logic [7:0]               compare_next;
  logic [7:0]               shadow_reg;
  logic [7:0]               shadow_next;
  logic [7:0]               count_reg;
  logic [7:0]               count_next;
  logic                     armed_reg;
  logic                     armed_next;
  logic [PRESCALE_BITS-1:0] prescale_reg;
  logic [PRESCALE_BITS-1:0] prescale_next;
  pins_type                 pins_reg;
  pins_type                 pins_next;
  logic                     pready_reg;
  logic                     pready_next;
  logic [31:0]              prdata_reg;
  logic [31:0]              prdata_next;
  logic                     pslverr_reg;
  logic                     pslverr_next;
  logic                     count_tick;
  logic                     fall_tick;

  // Address decode used by both write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ************************************************************
  // Source selection
  // ************************************************************
  tick_select u_tick (
    .clk             (clk),
    .nrst            (nrst),
    .src_sel         (ctrl_reg.source_clock_select),
    .sys             (sys),
    .run             (ctrl_reg.run_enable),
    .prescale        (prescale_reg),
    .low_freq_tick   (low_freq_tick),
    .count_input_pin (count_input_pin),
    .count_tick      (count_tick),
    .fall_tick       (fall_tick)
  );

  // ************************************************************
  // APB slave and registers
  // ************************************************************
  // Zero-wait access; reply registered so outputs come from flops
  always_comb begin
    logic setup;
    logic wr;
    logic rd;
    setup = psel && !penable;
    wr = psel && penable && pwrite && pready_reg;
    rd = setup && !pwrite;
    ctrl_next = ctrl_reg;
    compare_next = compare_reg;
    pready_next = setup;
    prdata_next = prdata_reg;
    pslverr_next = setup && !hit(paddr, CTRL_OFFSET) && !hit(paddr, COMPARE_OFFSET);
    // Write lands at the access edge, where the master samples pready
    if (wr) begin
      if (hit(paddr, CTRL_OFFSET)) begin
        ctrl_next.run_enable = pwdata[RUN_BIT];
        ctrl_next.source_clock_select = pwdata[SRC_LSB +: 3];
        ctrl_next.operating_mode_select = mode_type'(pwdata[MODE_LSB +: 2]);
      end else if (hit(paddr, COMPARE_OFFSET)) begin
        compare_next = pwdata[7:0];
      end
    end
    if (rd) begin
      if (hit(paddr, CTRL_OFFSET)) begin
        prdata_next = {24'h000000, 2'b00, ctrl_reg}; // bits 7:6 read zero
      end else if (hit(paddr, COMPARE_OFFSET)) begin
        prdata_next = {24'h000000, compare_reg};
      end else begin
        prdata_next = UNMAPPED_DATA;
        pslverr_next = 1'b1;
      end
    end
    // Stop entry overrides the run bit of any software write in the same cycle
    if (sys.stop_entry) begin
      ctrl_next.run_enable = 1'b0;
    end
  end

  // ************************************************************
  // Counter core
  // ************************************************************
  always_comb begin
    logic match;
    logic start;
    prescale_next = prescale_reg + {{(PRESCALE_BITS-1){1'b0}}, 1'b1};
    count_next = count_reg;
    shadow_next = shadow_reg;
    armed_next = armed_reg;
    pins_next = pins_reg;
    pins_next.match_interrupt = 1'b0;
    start = ctrl_reg.run_enable && !armed_reg;
    match = 1'b0;
    if (!ctrl_reg.run_enable) begin
      // Stopped: cleared count, idle-high outputs
      count_next = COUNT_ZERO;
      armed_next = 1'b0;
      pins_next.divider_output_pin = 1'b1;
      pins_next.pwm_output_pin = 1'b1;
    end else if (start) begin
      armed_next = 1'b1;
      shadow_next = compare_reg; // load on start
    end else begin
      case (ctrl_reg.operating_mode_select)
        MODE_TIMER, MODE_DIVIDER: begin
          // External source: count on rise, compare on fall
          if (count_tick) begin
            count_next = count_reg + 8'h01;
          end
          if (ctrl_reg.source_clock_select == SRC_EXT) begin
            match = fall_tick && (count_reg == compare_reg);
          end else begin
            match = count_tick && (count_reg + 8'h01 == compare_reg);
          end
          if (match) begin
            count_next = COUNT_ZERO;
            pins_next.match_interrupt = 1'b1;
            if (ctrl_reg.operating_mode_select == MODE_DIVIDER) begin
              pins_next.divider_output_pin = ~pins_reg.divider_output_pin;
            end
          end
        end
        MODE_PWM: begin
          if (count_tick) begin
            count_next = count_reg + 8'h01;
            if (count_reg + 8'h01 == shadow_reg) begin
              pins_next.pwm_output_pin = 1'b0;
            end
            if (count_reg == COUNT_MAX) begin
              pins_next.pwm_output_pin = 1'b1;
              pins_next.match_interrupt = 1'b1;
              shadow_next = compare_reg;
            end
          end
        end
        default: begin
          count_next = count_reg; // reserved mode holds
        end
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= ctrl_type'(CTRL_RESET[5:0]);
      compare_reg <= COMPARE_RESET;
      shadow_reg <= COMPARE_RESET;
      count_reg <= COUNT_ZERO;
      armed_reg <= 1'b0;
      prescale_reg <= '0;
      pins_reg <= 3'b110;
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      compare_reg <= compare_next;
      shadow_reg <= shadow_next;
      count_reg <= count_next;
      armed_reg <= armed_next;
      prescale_reg <= prescale_next;
      pins_reg <= pins_next;
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Outputs straight from flops
  assign pins = pins_reg;
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule // timer_counter
`default_nettype wire

// [tb/tb_top.sv]
// Testbench: register access and counting scenarios of the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmr_pkg::*;
  // ********
  // Signals
  // ********
  logic        clk = '0;
  logic        nrst = '0;
  logic        psel = '0;
  logic        penable = '0;
  logic        pwrite = '0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  sys_type     sys = '0;
  logic        lf_tick = '0;
  logic        ext_in = '0;
  pins_type    pins;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [7:0]  cyc = '0;
  logic        ext_on = '0;
  logic        lf_on = '0;
  logic        cnt_on = '0;
  logic        div_last;
  logic [31:0] r;
  int          n_mismatch, compares;
  integer      n_int, n_low, n_tog;
  logic [7:0]  cur = '0;
  integer      seed = 32'hA3DF;
  always #25 clk = ~clk;
  // Slow pulses: external input period 8, low-rate tick every 2nd cycle
  always @(posedge clk) begin
    cyc <= cyc + 8'h01;
    ext_in <= ext_on & cyc[2];
    lf_tick <= lf_on & cyc[0];
  end
  timer_counter i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sys(sys), .low_freq_tick(lf_tick), .count_input_pin(ext_in), .pins(pins));
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (x !== g) begin
      n_mismatch++;
      $display("wrong value %s: expected %0h, seen %0h", s, x, g);
    end
  endtask
  // Window tallies; read results against the oldest queued note
  always @(posedge clk) begin
    if (cnt_on) begin
      n_int += pins.match_interrupt;
      n_low += !pins.pwm_output_pin;
      n_tog += (pins.divider_output_pin != div_last);
    end
    div_last = pins.divider_output_pin;
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      chk("read data", e[31:0], prdata);
      chk("read error", {31'h0, e[32]}, {31'h0, pslverr});
    end
  end
  // Request held until pready is sampled; one idle edge avoids double drives
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    if (!w) exp_q.push_back(x);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (!pready);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, '0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    apb(1'h0, a, '0, x);
  endtask
  task automatic win(input int w);
    n_int = 0;
    n_low = 0;
    n_tog = 0;
    cnt_on <= 1'h1;
    repeat (w) @(posedge clk);
    cnt_on <= 1'h0;
    @(posedge clk);
  endtask
  // Stop with fields kept, reprogram while stopped, start, settle, count whole periods
  task automatic go(input logic [7:0] c, input logic [7:0] d, input int w, input int ei);
    wr(CTRL_OFFSET, {24'h0, cur & 8'h1F});
    wr(CTRL_OFFSET, {24'h0, c});
    wr(COMPARE_OFFSET, {24'h0, d});
    cur = c | 8'h20;
    wr(CTRL_OFFSET, {24'h0, cur});
    repeat (w) @(posedge clk);
    win(w);
    chk("interrupts", ei, n_int);
  endtask
  task automatic close_out;
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rd(CTRL_OFFSET, {1'h0, 32'h0});
    rd(COMPARE_OFFSET, {1'h0, 32'hFF});
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(CTRL_OFFSET, r & 32'hFFFF_FFDF);
      wr(8'h10, ~r);
      rd(CTRL_OFFSET, {1'h0, 27'h0, r[4:0]});
      wr(COMPARE_OFFSET, r | 32'h1);
      rd(COMPARE_OFFSET, {1'h0, 24'h0, r[7:1], 1'h1});
      rd(8'h10, {1'h1, UNMAPPED_DATA});
    end
    $display("test registers done");
    go(8'h0C, 8'h02, 160, 10);
    sys.prescale_halve_select <= 1'h1;
    go(8'h0C, 8'h02, 160, 5);
    sys.stop_entry <= 1'h1;
    @(posedge clk);
    sys.stop_entry <= 1'h0;
    sys.prescale_halve_select <= 1'h0;
    rd(CTRL_OFFSET, {1'h0, 32'h0C});
    win(20);
    chk("interrupts", 0, n_int);
    go(8'h0D, 8'h02, 160, 0);
    go(8'h0A, 8'h02, 320, 5);
    chk("toggles", 5, n_tog);
    wr(CTRL_OFFSET, 32'h0A);
    repeat (3) @(posedge clk);
    chk("divider idle", 1, pins.divider_output_pin);
    ext_on <= 1'h1;
    go(8'h1C, 8'h03, 96, 4);
    ext_on <= 1'h0;
    wr(CTRL_OFFSET, 32'h1C); // events stop before low speed
    sys.low_speed <= 1'h1;
    lf_on <= 1'h1;
    go(8'h0C, 8'h02, 160, 0);
    go(8'h00, 8'h01, 160, 10);
    sys.low_speed <= 1'h0;
    sys.divider_stage_select <= 1'h1;
    go(8'h00, 8'h01, 160, 10);
    go(8'h0C, 8'h02, 160, 10);
    sys.divider_stage_select <= 1'h0;
    $display("test counting done");
    go(8'h17, 8'h80, 1024, 2);
    chk("pwm low", 512, n_low);
    wr(COMPARE_OFFSET, 32'h40);
    repeat (600) @(posedge clk);
    win(1024);
    chk("pwm low", 768, n_low);
    chk("interrupts", 2, n_int);
    wr(CTRL_OFFSET, 32'h17);
    repeat (3) @(posedge clk);
    chk("pwm idle", 1, pins.pwm_output_pin);
    $display("test pwm done");
    close_out;
  end
  // Run is near 7000 cycles; cut a hang at 20000
  initial begin
    #1000000;
    n_mismatch++;
    close_out;
  end
endmodule // tb_top
`default_nettype wire

// [tb/tmr_monitor.sv]
// Checker: APB timing and stop-state behaviour of the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tmr_monitor
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // System and pins
  input wire tmr_pkg::sys_type  sys,
  input wire tmr_pkg::pins_type pins
);
  // ********
  // Assertions
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic map_ok;
  logic stop_wr;
  // Decoded address, and a control write that clears run
  assign map_ok = (paddr == CTRL_OFFSET) || (paddr == COMPARE_OFFSET);
  assign stop_wr = psel && penable && pwrite && (paddr == CTRL_OFFSET) && !pwdata[RUN_BIT];
  rdy_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  rdy_idle_a: assert property (!psel |=> !pready)
    else $error("ready without request");
  rdy_once_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  bad_addr_a: assert property (pready && !map_ok |-> pslverr)
    else $error("unmapped access without error");
  good_addr_a: assert property (pready && map_ok |-> !pslverr)
    else $error("error on mapped access");
  ctrl_read_a: assert property (pready && !pwrite && paddr == CTRL_OFFSET |-> prdata[31:6] == 26'h0)
    else $error("control read upper bits set");
  stop_pins_a: assert property (stop_wr |-> ##[1:3] (pins.divider_output_pin && pins.pwm_output_pin))
    else $error("pins not high after stop");
  stop_quiet_a: assert property (stop_wr |-> ##2 (!pins.match_interrupt) [*4])
    else $error("interrupt after stop");
  stop_entry_a: assert property (sys.stop_entry |-> ##[1:3] (pins.divider_output_pin && pins.pwm_output_pin))
    else $error("pins not high after stop entry");
  // Main scenarios seen
  cover property (pins.match_interrupt);
  cover property (pready && pslverr);
  cover property ($fell(pins.pwm_output_pin));
endmodule // tmr_monitor
bind timer_counter tmr_monitor i_mon (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .sys(sys), .pins(pins));
`default_nettype wire
